// ==== design/fbm_pkg.sv ====
// shared constants, types and carriers of the fieldbus master cycle control
package fbm_pkg;

    localparam int NUM_SLAVES = 4;
    localparam int MAX_LEN = 4;
    localparam int SLV_W = 2;
    localparam int BYTE_W = 2;
    localparam int LEN_W = 3;
    localparam int FIFO_DEPTH = 16;

    // timing: indicator blink half period
    localparam int CLK_HZ = 20_000_000;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int BLINK_W = 23;

    // reset values
    localparam logic [6:0] ADDR_RST = 7'h00;

    // telegram word kinds and global control commands
    localparam logic [1:0] K_GC = 2'h0;
    localparam logic [1:0] K_HDR = 2'h1;
    localparam logic [1:0] K_DATA = 2'h2;
    localparam logic [7:0] GC_CLEAR = 8'h02;
    localparam logic [7:0] GC_OPERATE = 8'h00;

    typedef enum logic [1:0] {ST_OFF, ST_ONLINE, ST_EXCH} fbm_state_t;
    typedef enum logic [1:0] {PH_GC, PH_HDR, PH_DATA} fbm_phase_t;

    // one word of the outgoing telegram stream
    typedef struct packed {
        logic [1:0] kind;
        logic [SLV_W-1:0] slave;
        logic [7:0] data;
    } fbm_tel_t;

    localparam int TEL_W = $bits(fbm_tel_t);

    // one input byte received from a slave
    typedef struct packed {
        logic [SLV_W-1:0] slave;
        logic [BYTE_W-1:0] idx;
        logic [7:0] data;
    } fbm_rx_t;

    typedef logic [NUM_SLAVES-1:0][MAX_LEN-1:0][7:0] fbm_image_t;
    typedef logic [NUM_SLAVES-1:0][LEN_W-1:0] fbm_lens_t;

    typedef struct packed {
        fbm_state_t st;
        logic online_ind;
        logic de_ind;
        logic [BLINK_W-1:0] blink_cnt;
        logic blink;
        logic run_cyc;
        fbm_phase_t ph;
        logic [SLV_W-1:0] slv;
        logic [BYTE_W-1:0] byt;
        logic [NUM_SLAVES-1:0] fail_safe;
        fbm_lens_t out_len;
        logic addr_resp;
        logic [6:0] own_addr;
        logic tx_valid;
        fbm_tel_t tx_word;
        logic in_we;
        fbm_rx_t in_word;
    } fbm_top_state_t;

endpackage : fbm_pkg

// ==== design/fbm_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module fbm_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fbm_fifo_state_t;

    fbm_fifo_state_t s;
    fbm_fifo_state_t next_s;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: next_s.cnt = s.cnt + 1'b1;
            2'b01: next_s.cnt = s.cnt - 1'b1;
            default: next_s.cnt = s.cnt;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    property p_count_step;
        @(posedge clk) disable iff (sys_rst)
        (push && !pop) |=> (s.cnt == $past(s.cnt) + 1'b1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("fifo count missed a push");

endmodule : fbm_fifo

// ==== design/fbm_master.sv ====
// fieldbus master cycle control: start-up, exchange cycle, stop/run handling
// Overview of operation
// - after power-on stay deactivated, indicators dark
// - bus parameters loaded: go online, online indicator
// - online without project: answer at own address
// - valid configuration: enter exchange, exchange indicator
// - power-on or new configuration forces full reload
// - processor stop: broadcast Clear, exchange indicator blinks
// - stop: fail-safe slaves get zero-length outputs
// - stop: other slaves get full-length zero outputs
// - stop: slave inputs still copied to input area
// - run: broadcast Operate, exchange indicator steady
// - run: every slave gets latest outputs each cycle
// - run: slave inputs copied to input area
`timescale 1ns/1ps
module fbm_master import fbm_pkg::*; #(
    parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_param_load,
    input wire logic [6:0] station_addr,
    input wire logic config_load,
    input wire logic config_ok,
    input wire logic [NUM_SLAVES-1:0] cfg_fail_safe,
    input wire fbm_lens_t cfg_out_len,
    input wire logic hw_config_new,
    input wire logic cpu_run,
    input wire fbm_image_t out_image,
    input wire logic rx_valid,
    input wire fbm_rx_t rx_word,
    input wire logic tx_ready,
    output logic tx_valid,
    output fbm_tel_t tx_word,
    output logic in_we,
    output fbm_rx_t in_word,
    output logic online_indicator,
    output logic data_exchange_indicator,
    output logic addr_respond,
    output logic [6:0] own_addr
);
    localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYCLES - 1);

    fbm_top_state_t s;
    fbm_top_state_t next_s;
    fbm_tel_t push_word;
    logic push_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    fbm_tel_t fifo_out_word;
    logic accept;
    logic [LEN_W-1:0] cur_len;

    // a full fifo stalls the sequencer, so no telegram word is ever dropped
    fbm_fifo #(
        .WIDTH(TEL_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_word)
    );

    assign fifo_out_ready = !s.tx_valid || tx_ready;
    assign accept = push_valid && fifo_in_ready;

    // fail-safe slaves see zero length while the processor is stopped
    assign cur_len = (!s.run_cyc && s.fail_safe[s.slv]) ? '0 : s.out_len[s.slv];

    // telegram word generation for the current phase
    always_comb begin
        push_valid = 1'b0;
        push_word = '0;
        if (s.st == ST_EXCH) begin
            push_valid = 1'b1;
            case (s.ph)
                PH_GC: begin
                    push_word.kind = K_GC;
                    push_word.data = cpu_run ? GC_OPERATE : GC_CLEAR;
                end
                PH_HDR: begin
                    push_word.kind = K_HDR;
                    push_word.slave = s.slv;
                    push_word.data = 8'(cur_len);
                end
                PH_DATA: begin
                    push_word.kind = K_DATA;
                    push_word.slave = s.slv;
                    // stopped: full length kept, contents forced to zero
                    push_word.data = s.run_cyc ? out_image[s.slv][s.byt] : 8'h00;
                end
                default: begin
                    push_valid = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        next_s = s;
        next_s.in_we = 1'b0;

        // start-up sequence and exchange cycle sequencing
        case (s.st)
            ST_OFF: begin
                if (bus_param_load) begin
                    next_s.st = ST_ONLINE;
                    next_s.own_addr = station_addr;
                end
            end
            ST_ONLINE: begin
                if (config_load && config_ok) begin
                    next_s.st = ST_EXCH;
                    next_s.fail_safe = cfg_fail_safe;
                    next_s.out_len = cfg_out_len;
                    next_s.ph = PH_GC;
                    next_s.slv = '0;
                    next_s.byt = '0;
                end
            end
            ST_EXCH: begin
                if (accept) begin
                    case (s.ph)
                        PH_GC: begin
                            // mode sampled once per cycle so command and data agree
                            next_s.run_cyc = cpu_run;
                            next_s.ph = PH_HDR;
                            next_s.slv = '0;
                        end
                        PH_HDR: begin
                            next_s.byt = '0;
                            if (cur_len != '0) begin
                                next_s.ph = PH_DATA;
                            end else if (s.slv == SLV_W'(NUM_SLAVES - 1)) begin
                                next_s.ph = PH_GC;
                            end else begin
                                next_s.slv = s.slv + 1'b1;
                            end
                        end
                        PH_DATA: begin
                            if (LEN_W'(s.byt) + 1'b1 == cur_len) begin
                                if (s.slv == SLV_W'(NUM_SLAVES - 1)) begin
                                    next_s.ph = PH_GC;
                                end else begin
                                    next_s.ph = PH_HDR;
                                    next_s.slv = s.slv + 1'b1;
                                end
                            end else begin
                                next_s.byt = s.byt + 1'b1;
                            end
                        end
                        default: begin
                            next_s.ph = PH_GC;
                        end
                    endcase
                end
                // inputs flow in both stop and run
                if (rx_valid) begin
                    next_s.in_we = 1'b1;
                    next_s.in_word = rx_word;
                end
            end
            default: begin
                next_s.st = ST_OFF;
            end
        endcase

        // a new configuration returns to OFF until parameters come again; queued telegram words still drain
        if (hw_config_new) begin
            next_s.st = ST_OFF;
            next_s.run_cyc = 1'b0;
            next_s.in_we = 1'b0;
        end

        // blink timer, free running in exchange
        if (next_s.st == ST_EXCH) begin
            if (s.blink_cnt >= BLINK_LAST) begin
                next_s.blink_cnt = '0;
                next_s.blink = !s.blink;
            end else begin
                next_s.blink_cnt = s.blink_cnt + 1'b1;
            end
        end else begin
            next_s.blink_cnt = '0;
            next_s.blink = 1'b0;
        end

        // indicators follow the next state so they change with it
        next_s.online_ind = (next_s.st != ST_OFF);
        next_s.de_ind = (next_s.st == ST_EXCH) && (next_s.run_cyc || next_s.blink);
        next_s.addr_resp = (next_s.st == ST_ONLINE);

        // output register stage of the telegram stream
        if (fifo_out_ready) begin
            next_s.tx_valid = fifo_out_valid;
            next_s.tx_word = fifo_out_valid ? fifo_out_word : s.tx_word;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= ST_OFF;
            s.ph <= PH_GC;
            s.own_addr <= ADDR_RST;
        end else begin
            s <= next_s;
        end
    end

    assign tx_valid = s.tx_valid;
    assign tx_word = s.tx_word;
    assign in_we = s.in_we;
    assign in_word = s.in_word;
    assign online_indicator = s.online_ind;
    assign data_exchange_indicator = s.de_ind;
    assign addr_respond = s.addr_resp;
    assign own_addr = s.own_addr;

    property p_off_dark;
        @(posedge clk) disable iff (sys_rst)
        (s.st == ST_OFF) |-> (!online_indicator && !data_exchange_indicator);
    endproperty
    a_off_dark: assert property (p_off_dark) else $error("indicator lit while deactivated");

    property p_go_online;
        @(posedge clk) disable iff (sys_rst)
        (s.st == ST_OFF && bus_param_load && !hw_config_new)
            |=> (online_indicator && own_addr == $past(station_addr));
    endproperty
    a_go_online: assert property (p_go_online) else $error("did not go online");

    property p_addr_resp;
        @(posedge clk) disable iff (sys_rst)
        (s.st == ST_ONLINE) |-> (addr_respond && online_indicator && !data_exchange_indicator);
    endproperty
    a_addr_resp: assert property (p_addr_resp) else $error("not answering at own address");

    property p_enter_exch;
        @(posedge clk) disable iff (sys_rst)
        (s.st == ST_ONLINE && config_load && config_ok && !hw_config_new)
            |=> (s.st == ST_EXCH && !addr_respond);
    endproperty
    a_enter_exch: assert property (p_enter_exch) else $error("exchange not entered");

    property p_reload;
        @(posedge clk) disable iff (sys_rst)
        // parameters may come again right after the drop, so only they may leave OFF
        hw_config_new |=> (s.st == ST_OFF && !online_indicator)
            ##1 (s.st == ST_OFF || $past(bus_param_load));
    endproperty
    a_reload: assert property (p_reload) else $error("no reload after new configuration");

    property p_gc_cmd;
        @(posedge clk) disable iff (sys_rst)
        (accept && push_word.kind == K_GC && !hw_config_new)
            |=> (s.run_cyc == $past(cpu_run))
                && ($past(push_word.data) == ($past(cpu_run) ? GC_OPERATE : GC_CLEAR));
    endproperty
    a_gc_cmd: assert property (p_gc_cmd) else $error("wrong global control command");

    property p_fail_safe_len;
        @(posedge clk) disable iff (sys_rst)
        (accept && push_word.kind == K_HDR && !s.run_cyc && s.fail_safe[s.slv])
            |-> (push_word.data == 8'h00);
    endproperty
    a_fail_safe_len: assert property (p_fail_safe_len) else $error("fail-safe length not zero");

    property p_stop_zero;
        @(posedge clk) disable iff (sys_rst)
        (accept && push_word.kind == K_DATA && !s.run_cyc) |-> (push_word.data == 8'h00);
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("nonzero output while stopped");

    property p_inputs;
        @(posedge clk) disable iff (sys_rst)
        (s.st == ST_EXCH && rx_valid && !hw_config_new)
            |=> (in_we && in_word == $past(rx_word));
    endproperty
    a_inputs: assert property (p_inputs) else $error("slave input not copied");

    property p_run_steady;
        @(posedge clk) disable iff (sys_rst)
        (s.st == ST_EXCH && s.run_cyc) |-> data_exchange_indicator;
    endproperty
    a_run_steady: assert property (p_run_steady) else $error("indicator not steady in run");

    property p_mode_hold;
        @(posedge clk) disable iff (sys_rst)
        (s.st == ST_EXCH && !(accept && s.ph == PH_GC) && !hw_config_new)
            |=> $stable(s.run_cyc);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid cycle");

endmodule : fbm_master

// ==== verif/fbm_slave_model.sv ====
// behavioural model of the polled slave stations on the far side
`timescale 1ns/1ps
module fbm_slave_model import fbm_pkg::*; (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic reply,
    output logic tx_ready,
    output logic rx_valid,
    output fbm_rx_t rx_word
);
    // configurer side: watchdog factor up to 1.5 Mbit/s and above it
    localparam int WD_FACTOR_LOW = 3;
    localparam int WD_FACTOR_HIGH = 6;
    logic [7:0] cnt = 8'h00;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_word = '0;
    end
    // mode 0 prompt, 1 slow (one take in four), 2 halted
    always @(negedge clk) begin
        cnt <= cnt + 8'h01;
        tx_ready <= (mode == 2'h0) || (mode == 2'h1 && cnt[1:0] == 2'h3);
        rx_valid <= reply && cnt[0];
        // released line toggles each cycle between the last byte and its inverse
        rx_word <= reply ? {cnt[5:4], cnt[3:2], cnt ^ 8'hA5} : ~rx_word;
    end
endmodule : fbm_slave_model

// ==== verif/fbm_master_bench.sv ====
// self-checking bench of the fieldbus master cycle control
`timescale 1ns/1ps
module fbm_master_bench import fbm_pkg::*; ();
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_param_load = 1'b0;
    logic [6:0] station_addr = 7'h00;
    logic config_load = 1'b0;
    logic config_ok = 1'b0;
    logic [NUM_SLAVES-1:0] cfg_fail_safe = 4'h5;
    fbm_lens_t cfg_out_len;
    logic hw_config_new = 1'b0;
    logic cpu_run = 1'b0;
    fbm_image_t out_image;
    logic rx_valid, tx_ready, tx_valid, in_we;
    logic online_indicator, data_exchange_indicator, addr_respond;
    fbm_rx_t rx_word, in_word;
    fbm_tel_t tx_word;
    logic [6:0] own_addr;
    logic [1:0] mode = 2'h0;
    logic reply = 1'b0;
    logic in_exch = 1'b0;
    int err_total = 0;
    int cmp_count = 0;
    fbm_tel_t txq[$];
    fbm_rx_t inq[$];
    fbm_rx_t rxq[$];

    always #25 clk = ~clk;

    fbm_master #(.BLINK_CYCLES(8)) u_fbm_master (.clk(clk), .sys_rst(sys_rst),
        .bus_param_load(bus_param_load), .station_addr(station_addr),
        .config_load(config_load), .config_ok(config_ok), .cfg_fail_safe(cfg_fail_safe),
        .cfg_out_len(cfg_out_len), .hw_config_new(hw_config_new), .cpu_run(cpu_run),
        .out_image(out_image), .rx_valid(rx_valid), .rx_word(rx_word), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_word(tx_word), .in_we(in_we), .in_word(in_word),
        .online_indicator(online_indicator), .data_exchange_indicator(data_exchange_indicator),
        .addr_respond(addr_respond), .own_addr(own_addr));

    fbm_slave_model u_fbm_slave_model (.clk(clk), .mode(mode), .reply(reply),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_word(rx_word));

    always @(posedge clk) begin
        if (tx_valid && tx_ready) txq.push_back(tx_word);
        if (in_we) inq.push_back(in_word);
        if (rx_valid && in_exch) rxq.push_back(rx_word);
    end

    task complete_run;
        $display("errors %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task pulse(input int k);
        @(negedge clk);
        case (k)
            0: bus_param_load = 1'b1;
            1: config_load = 1'b1;
            default: hw_config_new = 1'b1;
        endcase
        @(negedge clk);
        bus_param_load = 1'b0;
        config_load = 1'b0;
        hw_config_new = 1'b0;
    endtask : pulse

    task pop(output fbm_tel_t w);
        int n;
        n = 0;
        while (txq.size() == 0 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (txq.size() == 0) begin
            err_total++;
            $display("BAD %0t no telegram word", $time);
            complete_run;
        end else begin
            w = txq.pop_front();
        end
    endtask : pop

    // skips to the next cycle start of the wanted mode, then checks one whole cycle
    task chk_cycle(input logic run);
        fbm_tel_t w;
        logic [2:0] len;
        logic [7:0] gc;
        int n;
        // all ones is no global control word, so the search always pops
        w = '1;
        gc = run ? GC_OPERATE : GC_CLEAR;
        n = 0;
        while (!(w.kind === K_GC && w.data === gc) && n < 200) begin
            pop(w);
            n++;
        end
        check({w.kind, w.data}, {K_GC, gc});
        if (w.kind !== K_GC || w.data !== gc) begin
            complete_run;
        end
        for (int s = 0; s < NUM_SLAVES; s++) begin
            pop(w);
            len = (!run && cfg_fail_safe[s]) ? 3'h0 : cfg_out_len[s];
            check(w, {K_HDR, 2'(s), 5'h00, len});
            for (int b = 0; b < len; b++) begin
                pop(w);
                check(w, {K_DATA, 2'(s), run ? out_image[s][b] : 8'h00});
            end
        end
    endtask : chk_cycle

    task chk_rx;
        repeat (3) @(negedge clk);
        check(inq.size(), rxq.size());
        while (rxq.size() > 0 && inq.size() > 0) begin
            check(inq.pop_front(), rxq.pop_front());
        end
    endtask : chk_rx

    task t_start;
        check({online_indicator, data_exchange_indicator, addr_respond, own_addr}, '0);
        config_ok = 1'b1;
        pulse(1);
        check(online_indicator, 1'b0);
        station_addr = 7'h2A;
        pulse(0);
        check({online_indicator, addr_respond, own_addr}, {2'h3, 7'h2A});
        station_addr = 7'h55;
        pulse(0);
        check(own_addr, 7'h2A);
        config_ok = 1'b0;
        pulse(1);
        check({addr_respond, data_exchange_indicator}, 2'h2);
    endtask : t_start

    task t_stop;
        int ch;
        logic last;
        config_ok = 1'b1;
        pulse(1);
        check({online_indicator, addr_respond}, 2'h2);
        in_exch = 1'b1;
        reply <= 1'b1;
        chk_cycle(1'b0);
        chk_cycle(1'b0);
        ch = 0;
        last = data_exchange_indicator;
        repeat (32) begin
            @(negedge clk);
            if (data_exchange_indicator !== last) ch++;
            last = data_exchange_indicator;
        end
        check(ch, 4);
        reply <= 1'b0;
        chk_rx;
    endtask : t_stop

    task t_run;
        cpu_run = 1'b1;
        reply <= 1'b1;
        chk_cycle(1'b1);
        repeat (16) begin
            @(negedge clk);
            check(data_exchange_indicator, 1'b1);
        end
        reply <= 1'b0;
        chk_rx;
    endtask : t_run

    // halted link fills the fifo; the word on offer must stand and nothing may be lost
    task t_stall;
        fbm_tel_t w0;
        int n0;
        mode <= 2'h2;
        repeat (40) @(negedge clk);
        w0 = tx_word;
        n0 = txq.size();
        repeat (40) @(negedge clk);
        check({tx_valid, tx_word}, {1'b1, w0});
        check(txq.size(), n0);
        mode <= 2'h1;
        chk_cycle(1'b1);
        chk_cycle(1'b1);
        mode <= 2'h0;
    endtask : t_stall

    task t_hwnew;
        in_exch = 1'b0;
        pulse(2);
        check({online_indicator, data_exchange_indicator, addr_respond}, 3'h0);
        pulse(1);
        check(data_exchange_indicator, 1'b0);
        station_addr = 7'h11;
        pulse(0);
        check({addr_respond, own_addr}, {1'b1, 7'h11});
        // words of the dropped cycle still drain; judge only the new start
        repeat (20) @(negedge clk);
        txq.delete();
        pulse(1);
        chk_cycle(1'b1);
    endtask : t_hwnew

    initial begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
            for (int b = 0; b < MAX_LEN; b++) out_image[s][b] = 8'(16 * s + b + 1);
        end
        cfg_out_len = {3'h0, 3'h1, 3'h3, 3'h4};
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        t_start;
        t_stop;
        t_run;
        t_stall;
        t_hwnew;
        complete_run;
    end
endmodule : fbm_master_bench
